// >>> rsc_pkg.sv
package rsc_pkg;

  localparam int unsigned NUM_LVL = 4;
  localparam int unsigned LVL_REGS = 16;
  localparam int unsigned NUM_REGS = 64;

  // Storage window held here, byte addresses
  localparam logic [15:0] REG_AREA_END = 16'h0080;
  localparam logic [15:0] DISP_AREA_END = 16'h0200;
  localparam logic [15:0] SIZE_ADDR = 16'h00AA;
  localparam logic [15:0] SIZE_RST = 16'h0000;
  localparam logic [15:0] SZ_16K = 16'h3FFF;
  localparam logic [15:0] SZ_32K = 16'h7FFF;
  localparam logic [15:0] SZ_48K = 16'hBFFF;
  localparam logic [15:0] SZ_64K = 16'hFFFF;
  localparam logic [15:0] UADDR_INC = 16'h0002;

  // Bring-up letters, index 0 is A
  localparam logic [4:0] CP_A = 5'h00;
  localparam logic [4:0] CP_I = 5'h08;
  localparam logic [4:0] CP_Q = 5'h10;
  localparam logic [4:0] CP_STEP = 5'h01;

  // Display half selector
  localparam logic [1:0] SEL_ALL = 2'h0;
  localparam logic [1:0] SEL_LEFT = 2'h1;
  localparam logic [1:0] SEL_RIGHT = 2'h2;
  localparam logic [7:0] HALF_REGS = 8'h20;
  localparam logic [7:0] ALL_REGS = 8'h40;

  // Control port register offsets
  localparam logic [2:0] REG_STATE = 3'h0;
  localparam logic [2:0] REG_IRQ = 3'h1;
  localparam logic [2:0] REG_MASK = 3'h2;
  localparam logic [2:0] REG_CHKPT = 3'h3;
  localparam logic [2:0] REG_SIZE = 3'h4;

  // State register fields
  localparam int unsigned ST_MODE = 0;
  localparam int unsigned ST_CHECK = 3;
  localparam int unsigned ST_SZ_VALID = 4;
  localparam int unsigned ST_SZ_LEGAL = 5;
  localparam int unsigned ST_STRAP = 6;
  localparam int unsigned ST_RUN_SW = 7;

  // Interrupt status and mask fields
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_STOP = 0;
  localparam int unsigned IRQ_HALT = 1;
  localparam int unsigned IRQ_CHECK = 2;
  localparam int unsigned IRQ_SIZE = 3;
  localparam logic [3:0] MASK_RST = 4'h0;

  typedef enum logic [2:0] {
    RSC_STOP,
    RSC_RUN,
    RSC_DRAIN,
    RSC_STEP,
    RSC_HALT,
    RSC_CHECK
  } rsc_mode_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [15:0] addr;
    logic [15:0] wdata;
  } rsc_stor_req_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [2:0] addr;
    logic [15:0] wdata;
  } rsc_reg_req_t;

  typedef struct packed {
    logic done;
    logic halt;
    logic branch;
    logic [15:0] target;
  } rsc_uinst_t;

  typedef struct packed {
    logic run;
    logic step;
    logic disp;
    logic [1:0] sel;
    logic strap;
  } rsc_pins_t;

  typedef struct packed {
    logic [63:0][15:0] rf;
    logic [15:0] size;
    logic [4:0] cp;
    rsc_mode_t mode;
    rsc_pins_t s1;
    rsc_pins_t s2;
    logic step_arm;
    logic step_last;
    logic chk;
    logic size_bad;
    logic [3:0] irq;
    logic [3:0] mask;
    logic [15:0] reg_rd;
    logic [15:0] stor_rd;
    logic stor_hit;
    logic [15:0] disp_rd;
    logic disp_ok;
    logic exec;
    logic irq_out;
    logic sz_valid;
  } rsc_state_t;

endpackage

// >>> rsc_top.sv
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps

module rsc_top (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire rsc_pkg::rsc_stor_req_t stor_i,
  output logic [15:0] stor_rdata_o,
  output logic stor_hit_o,
  input wire rsc_pkg::rsc_reg_req_t reg_i,
  output logic [15:0] reg_rdata_o,
  input wire rsc_pkg::rsc_uinst_t uinst_i,
  input wire logic [1:0] level_i,
  input wire logic parity_err_i,
  input wire logic mchk_i,
  input wire rsc_pkg::rsc_pins_t pins_i,
  input wire logic [7:0] disp_idx_i,
  output logic [15:0] disp_data_o,
  output logic disp_ok_o,
  output logic exec_en_o,
  output logic proc_check_o,
  output logic [4:0] chkpt_o,
  output logic size_valid_o,
  output logic irq_o
);

  //////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic sz_legal(input logic [15:0] v);
    logic ok;
    ok = 1'b0;
    case (v)
      rsc_pkg::SZ_16K: ok = 1'b1;
      rsc_pkg::SZ_32K: ok = 1'b1;
      rsc_pkg::SZ_48K: ok = 1'b1;
      rsc_pkg::SZ_64K: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Word reached by a byte address; bit 0 register file, bit 1 size word
  function automatic logic [1:0] word_kind(input logic [15:0] addr);
    logic [1:0] k;
    k = 2'h0;
    if (addr < rsc_pkg::REG_AREA_END) begin
      k[0] = 1'b1;
    end else if (addr[15:1] == rsc_pkg::SIZE_ADDR[15:1]) begin
      k[1] = 1'b1;
    end
    return k;
  endfunction

  // Size word trusted from checkpoint I on
  function automatic logic cp_ready(input logic [4:0] cp);
    return cp >= rsc_pkg::CP_I;
  endfunction

  // Modes in which the core may run microinstructions
  function automatic logic is_exec(input rsc_pkg::rsc_mode_t m);
    logic r;
    r = 1'b0;
    case (m)
      rsc_pkg::RSC_RUN: r = 1'b1;
      rsc_pkg::RSC_DRAIN: r = 1'b1;
      rsc_pkg::RSC_STEP: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Display slot to halfword index; 8'hFF marks a blank slot
  function automatic logic [7:0] disp_map(
    input logic [1:0] sel,
    input logic [7:0] idx
  );
    logic [7:0] r;
    r = idx;
    if (sel == rsc_pkg::SEL_LEFT || sel == rsc_pkg::SEL_RIGHT) begin
      if (idx < rsc_pkg::HALF_REGS) begin
        r = {2'b00, idx[4], sel == rsc_pkg::SEL_RIGHT, idx[3:0]};
      end else if (idx < rsc_pkg::ALL_REGS) begin
        r = 8'hFF;
      end
    end
    return r;
  endfunction

  // Halfword index in the lowest 512 bytes; {hit, data}
  function automatic logic [16:0] hw_read(
    input logic [63:0][15:0] rf,
    input logic [15:0] size,
    input logic [7:0] idx
  );
    logic [16:0] r;
    logic [1:0] k;
    r = {1'b0, 16'h0000};
    k = word_kind({7'h00, idx, 1'b0});
    if (k[0]) begin
      r = {1'b1, rf[idx[5:0]]};
    end else if (k[1]) begin
      r = {1'b1, size};
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // State

  rsc_pkg::rsc_state_t q;
  rsc_pkg::rsc_state_t d;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic run;
    logic step;
    logic disp;
    logic [1:0] sel;
    logic strap;
    logic step_rel;
    logic executing;
    logic err;
    logic [5:0] r0;
    logic [5:0] widx;
    logic [1:0] wk;
    logic [7:0] didx;
    logic [16:0] rd;
    logic [3:0] ev;
    logic [3:0] w1c;
    logic sz_ok;
    run = 1'b0;
    step = 1'b0;
    disp = 1'b0;
    sel = 2'h0;
    strap = 1'b0;
    step_rel = 1'b0;
    executing = 1'b0;
    err = 1'b0;
    r0 = 6'h00;
    widx = 6'h00;
    wk = 2'h0;
    didx = 8'h00;
    rd = 17'h00000;
    ev = 4'h0;
    w1c = 4'h0;
    sz_ok = 1'b0;
    d = q;

    // Pin synchronisers
    d.s1 = pins_i;
    d.s2 = q.s1;
    run = q.s2.run;
    step = q.s2.step;
    disp = q.s2.disp;
    sel = q.s2.sel;
    strap = q.s2.strap;

    // Step press then release, armed only by a press seen while stopped
    d.step_last = step;
    if (q.mode != rsc_pkg::RSC_STOP) begin
      d.step_arm = 1'b0;
    end else if (step && !q.step_last) begin
      d.step_arm = 1'b1;
    end else if (!step && q.step_arm) begin
      d.step_arm = 1'b0;
      step_rel = 1'b1;
    end

    executing = is_exec(q.mode);

    // Run and step sequencing
    case (q.mode)
      rsc_pkg::RSC_STOP: begin
        if (run) begin
          d.mode = rsc_pkg::RSC_RUN;
        end else if (step_rel) begin
          d.mode = rsc_pkg::RSC_STEP;
        end
      end
      rsc_pkg::RSC_RUN: begin
        if (!run) begin
          d.mode = rsc_pkg::RSC_DRAIN;
        end
      end
      rsc_pkg::RSC_DRAIN: begin
        if (run) begin
          d.mode = rsc_pkg::RSC_RUN;
        end else if (uinst_i.done) begin
          d.mode = rsc_pkg::RSC_STOP;
          ev[rsc_pkg::IRQ_STOP] = 1'b1;
        end
      end
      rsc_pkg::RSC_STEP: begin
        if (uinst_i.done) begin
          d.mode = rsc_pkg::RSC_STOP;
          ev[rsc_pkg::IRQ_STOP] = 1'b1;
        end
      end
      rsc_pkg::RSC_HALT: begin
        if (!run) begin
          d.mode = rsc_pkg::RSC_STOP;
        end
      end
      rsc_pkg::RSC_CHECK: begin
        d.mode = rsc_pkg::RSC_CHECK;
      end
      default: begin
        d.mode = rsc_pkg::RSC_STOP;
      end
    endcase

    // Halt microinstruction overrides a normal stop
    if (executing && uinst_i.done && uinst_i.halt) begin
      d.mode = rsc_pkg::RSC_HALT;
      ev[rsc_pkg::IRQ_HALT] = 1'b1;
      ev[rsc_pkg::IRQ_STOP] = 1'b0;
    end

    // Errors stop at once and stay latched until reset
    err = parity_err_i || (mchk_i && strap);
    if (err && !q.chk) begin
      d.chk = 1'b1;
      d.mode = rsc_pkg::RSC_CHECK;
      ev = 4'h0;
      ev[rsc_pkg::IRQ_CHECK] = 1'b1;
    end

    // Storage writes into the register area and size word
    widx = stor_i.addr[6:1];
    wk = word_kind(stor_i.addr);
    if (stor_i.we) begin
      if (wk[0]) begin
        d.rf[widx] = stor_i.wdata;
      end else if (wk[1]) begin
        d.size = stor_i.wdata;
      end
    end

    // Register 0 of the active level follows the microprogram
    r0 = {level_i, 4'h0};
    if (executing && uinst_i.done && !uinst_i.halt && !err) begin
      if (uinst_i.branch) begin
        d.rf[r0] = uinst_i.target;
      end else begin
        d.rf[r0] = q.rf[r0] + rsc_pkg::UADDR_INC;
      end
    end

    // Control port writes
    if (reg_i.we) begin
      case (reg_i.addr)
        rsc_pkg::REG_IRQ: begin
          w1c = reg_i.wdata[3:0];
        end
        rsc_pkg::REG_MASK: begin
          d.mask = reg_i.wdata[3:0];
        end
        rsc_pkg::REG_CHKPT: begin
          if (reg_i.wdata[4:0] == rsc_pkg::CP_A) begin
            d.cp = rsc_pkg::CP_A;
          end else if (q.cp < rsc_pkg::CP_Q &&
                       reg_i.wdata[4:0] == q.cp + rsc_pkg::CP_STEP) begin
            d.cp = reg_i.wdata[4:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Size word checks
    sz_ok = sz_legal(d.size);
    d.size_bad = cp_ready(d.cp) && !sz_ok;
    if (d.size_bad && !q.size_bad) begin
      ev[rsc_pkg::IRQ_SIZE] = 1'b1;
    end

    // Sticky status; a new event beats the clear
    d.irq = (q.irq & ~w1c) | ev;
    d.irq_out = |(d.irq & d.mask);

    // Control port reads, data in the next cycle
    d.reg_rd = 16'h0000;
    if (reg_i.re) begin
      case (reg_i.addr)
        rsc_pkg::REG_STATE: begin
          d.reg_rd[rsc_pkg::ST_MODE +: 3] = q.mode;
          d.reg_rd[rsc_pkg::ST_CHECK] = q.chk;
          d.reg_rd[rsc_pkg::ST_SZ_VALID] = cp_ready(q.cp);
          d.reg_rd[rsc_pkg::ST_SZ_LEGAL] = sz_legal(q.size);
          d.reg_rd[rsc_pkg::ST_STRAP] = strap;
          d.reg_rd[rsc_pkg::ST_RUN_SW] = run;
        end
        rsc_pkg::REG_IRQ: begin
          d.reg_rd[3:0] = q.irq;
        end
        rsc_pkg::REG_MASK: begin
          d.reg_rd[3:0] = q.mask;
        end
        rsc_pkg::REG_CHKPT: begin
          d.reg_rd[4:0] = q.cp;
        end
        rsc_pkg::REG_SIZE: begin
          d.reg_rd = q.size;
        end
        default: begin
          d.reg_rd = 16'h0000;
        end
      endcase
    end

    // Storage reads, data in the next cycle
    rd = hw_read(q.rf, q.size, stor_i.addr[8:1]);
    d.stor_hit = 1'b0;
    d.stor_rd = 16'h0000;
    if (stor_i.re && stor_i.addr < rsc_pkg::DISP_AREA_END) begin
      d.stor_hit = rd[16];
      d.stor_rd = rd[15:0];
    end

    // Register display
    didx = disp_map(sel, disp_idx_i);
    rd = hw_read(q.rf, q.size, didx);
    d.disp_ok = disp && rd[16] && didx != 8'hFF;
    d.disp_rd = d.disp_ok ? rd[15:0] : 16'h0000;

    d.exec = is_exec(d.mode);
    d.sz_valid = cp_ready(d.cp);
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs

  assign stor_rdata_o = q.stor_rd;
  assign stor_hit_o = q.stor_hit;
  assign reg_rdata_o = q.reg_rd;
  assign disp_data_o = q.disp_rd;
  assign disp_ok_o = q.disp_ok;
  assign exec_en_o = q.exec;
  assign proc_check_o = q.chk;
  assign chkpt_o = q.cp;
  assign size_valid_o = q.sz_valid;
  assign irq_o = q.irq_out;

endmodule

// >>> rsc_top_assertions.sv
`timescale 1ns/1ps
module rsc_top_assertions (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire rsc_pkg::rsc_stor_req_t stor_i,
  input wire logic [15:0] stor_rdata_o,
  input wire logic stor_hit_o,
  input wire rsc_pkg::rsc_uinst_t uinst_i,
  input wire logic parity_err_i,
  input wire logic exec_en_o,
  input wire logic proc_check_o,
  input wire logic [4:0] chkpt_o,
  input wire logic size_valid_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////
  sequence s_checked;
    ##[1:2] proc_check_o ##1 !exec_en_o;
  endsequence
  sequence s_halted;
    ##[1:2] !exec_en_o;
  endsequence
  property p_reg_hit;
    stor_i.re && stor_i.addr < 16'h0080 |=> stor_hit_o;
  endproperty
  property p_far_miss;
    stor_i.re && stor_i.addr >= 16'h0200 |=> !stor_hit_o && stor_rdata_o == 16'h0000;
  endproperty
  property p_chk_stop;
    parity_err_i |-> s_checked;
  endproperty
  property p_chk_hold;
    proc_check_o |=> proc_check_o && !exec_en_o;
  endproperty
  property p_halt;
    exec_en_o && uinst_i.done && uinst_i.halt |-> s_halted;
  endproperty
  property p_cp_step;
    $changed(chkpt_o) |-> chkpt_o == 5'h00 || chkpt_o == $past(chkpt_o) + 5'h01;
  endproperty
  property p_cp_max;
    chkpt_o <= 5'h10;
  endproperty
  property p_sz_valid;
    $stable(chkpt_o >= 5'h08) |-> size_valid_o == (chkpt_o >= 5'h08);
  endproperty
  a_reg_hit: assert property (p_reg_hit) else $error("register area read missed");
  a_far_miss: assert property (p_far_miss) else $error("read beyond display area hit");
  a_chk_stop: assert property (p_chk_stop) else $error("parity error did not stop");
  a_chk_hold: assert property (p_chk_hold) else $error("check latch not held");
  a_halt: assert property (p_halt) else $error("halt did not stop");
  a_cp_step: assert property (p_cp_step) else $error("checkpoint skipped a letter");
  a_cp_max: assert property (p_cp_max) else $error("checkpoint past last letter");
  a_sz_valid: assert property (p_sz_valid) else $error("size valid wrong");
endmodule

bind rsc_top rsc_top_assertions rsc_top_assertions_i (.clk_i(clk_i), .nrst_i(nrst_i), .stor_i(stor_i),
  .stor_rdata_o(stor_rdata_o), .stor_hit_o(stor_hit_o), .uinst_i(uinst_i), .parity_err_i(parity_err_i),
  .exec_en_o(exec_en_o), .proc_check_o(proc_check_o), .chkpt_o(chkpt_o), .size_valid_o(size_valid_o));

// >>> tb_rsc_top.sv
`timescale 1ns/1ps
module tb_rsc_top;
  logic clk_i, nrst_i, par, mck, hit, dok, ex, pchk, sv, irq;
  rsc_pkg::rsc_stor_req_t st;
  rsc_pkg::rsc_reg_req_t rg;
  rsc_pkg::rsc_uinst_t ui;
  rsc_pkg::rsc_pins_t pn;
  logic [1:0] lvl;
  logic [7:0] idx;
  logic [15:0] srd, rrd, dd;
  logic [4:0] cp;
  logic [15:0] sz [5] = '{rsc_pkg::SZ_16K, rsc_pkg::SZ_32K, rsc_pkg::SZ_48K, rsc_pkg::SZ_64K, 16'hBFFE};
  int failures, checks;
  rsc_top rsc_top_i (.clk_i(clk_i), .nrst_i(nrst_i), .stor_i(st), .stor_rdata_o(srd), .stor_hit_o(hit),
    .reg_i(rg), .reg_rdata_o(rrd), .uinst_i(ui), .level_i(lvl), .parity_err_i(par), .mchk_i(mck),
    .pins_i(pn), .disp_idx_i(idx), .disp_data_o(dd), .disp_ok_o(dok), .exec_en_o(ex),
    .proc_check_o(pchk), .chkpt_o(cp), .size_valid_o(sv), .irq_o(irq));
  ////////////////////////////////////////
  task automatic end_of_test();
    if (failures == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic reg_acc(input logic w, input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_i);
    rg <= '{w, ~w, a, d};
    @(posedge clk_i);
    rg <= '0;
    #1;
  endtask
  task automatic st_acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    st <= '{w, ~w, a, d};
    @(posedge clk_i);
    st <= '0;
    #1;
  endtask
  task automatic pins(input logic r, input logic s, input logic [1:0] sl);
    @(posedge clk_i);
    pn <= '{r, s, 1'b1, sl, 1'b0};
    cyc(5);
  endtask
  task automatic dsp(input logic [7:0] i, input logic [15:0] e);
    @(posedge clk_i);
    idx <= i;
    cyc(2);
    chk("display", dd, e);
  endtask
  task automatic dn(input logic h, input logic b, input logic [15:0] t);
    @(posedge clk_i);
    ui <= '{1'b1, h, b, t};
    @(posedge clk_i);
    ui <= '0;
    #1;
  endtask
  task automatic err(input logic p);
    @(posedge clk_i);
    par <= p;
    mck <= ~p;
    @(posedge clk_i);
    par <= 1'b0;
    mck <= 1'b0;
    cyc(2);
  endtask
  ////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Whole sequence needs under 1500 cycles
  initial begin
    #50000;
    failures++;
    end_of_test();
  end
  initial begin
    failures = 0;
    checks = 0;
    nrst_i = 1'b0;
    {st, rg, ui, pn, par, mck, idx} = '0;
    lvl = 2'h3;
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    cyc(1);
    for (int i = 0; i < 64; i++) st_acc(1'b1, 16'(2 * i), 16'hA000 | 16'(i));
    for (int i = 0; i < 64; i++) begin
      st_acc(1'b0, 16'(2 * i + 1), 16'h0000);
      chk("stor", srd, 16'hA000 | 16'(i));
    end
    st_acc(1'b0, 16'h0080, 16'h0000);
    chk("hit", 16'(hit), 16'h0000);
    st_acc(1'b0, 16'h0200, 16'h0000);
    chk("hit", 16'(hit), 16'h0000);
    st_acc(1'b1, rsc_pkg::SIZE_ADDR, 16'h1234);
    reg_acc(1'b1, rsc_pkg::REG_MASK, 16'h0008);
    for (int i = 1; i < 9; i++) begin
      chk("valid", 16'(sv), 16'h0000);
      reg_acc(1'b1, rsc_pkg::REG_CHKPT, 16'(i));
    end
    reg_acc(1'b1, rsc_pkg::REG_CHKPT, 16'h000A);
    cyc(1);
    chk("chkpt", 16'(cp), 16'h0008);
    chk("valid", 16'(sv), 16'h0001);
    chk("irq", 16'(irq), 16'h0001);
    reg_acc(1'b1, rsc_pkg::REG_IRQ, 16'h0008);
    cyc(1);
    chk("irq", 16'(irq), 16'h0000);
    foreach (sz[i]) begin
      st_acc(1'b1, rsc_pkg::SIZE_ADDR, sz[i]);
      reg_acc(1'b0, rsc_pkg::REG_STATE, 16'h0000);
      chk("legal", rrd & 16'h0020, i < 4 ? 16'h0020 : 16'h0000);
    end
    cyc(1);
    chk("irq", 16'(irq), 16'h0001);
    st_acc(1'b0, rsc_pkg::SIZE_ADDR, 16'h0000);
    chk("size", srd, 16'hBFFE);
    reg_acc(1'b1, rsc_pkg::REG_CHKPT, 16'h0000);
    cyc(1);
    chk("valid", 16'(sv), 16'h0000);
    pins(1'b0, 1'b0, rsc_pkg::SEL_LEFT);
    dsp(8'h10, 16'hA020);
    pins(1'b0, 1'b0, rsc_pkg::SEL_RIGHT);
    dsp(8'h11, 16'hA031);
    pins(1'b0, 1'b0, rsc_pkg::SEL_ALL);
    dsp(8'h3F, 16'hA03F);
    dsp(8'h55, 16'hBFFE);
    pins(1'b1, 1'b0, rsc_pkg::SEL_ALL);
    chk("exec", 16'(ex), 16'h0001);
    repeat (3) dn(1'b0, 1'b0, 16'h0000);
    st_acc(1'b0, 16'h0060, 16'h0000);
    chk("r0", srd, 16'hA036);
    dn(1'b0, 1'b1, 16'h0ABC);
    pins(1'b0, 1'b0, rsc_pkg::SEL_ALL);
    chk("exec", 16'(ex), 16'h0001);
    dn(1'b0, 1'b0, 16'h0000);
    cyc(1);
    chk("exec", 16'(ex), 16'h0000);
    pins(1'b0, 1'b1, rsc_pkg::SEL_ALL);
    chk("exec", 16'(ex), 16'h0000);
    pins(1'b0, 1'b0, rsc_pkg::SEL_ALL);
    chk("exec", 16'(ex), 16'h0001);
    dn(1'b0, 1'b0, 16'h0000);
    cyc(3);
    chk("exec", 16'(ex), 16'h0000);
    pins(1'b1, 1'b0, rsc_pkg::SEL_ALL);
    pins(1'b1, 1'b1, rsc_pkg::SEL_ALL);
    pins(1'b1, 1'b0, rsc_pkg::SEL_ALL);
    dn(1'b0, 1'b0, 16'h0000);
    cyc(1);
    chk("exec", 16'(ex), 16'h0001);
    dn(1'b1, 1'b0, 16'h0000);
    chk("exec", 16'(ex), 16'h0000);
    st_acc(1'b0, 16'h0060, 16'h0000);
    chk("r0", srd, 16'h0AC2);
    pins(1'b0, 1'b0, rsc_pkg::SEL_ALL);
    pins(1'b1, 1'b0, rsc_pkg::SEL_ALL);
    err(1'b0);
    chk("check", 16'(pchk), 16'h0000);
    chk("exec", 16'(ex), 16'h0001);
    err(1'b1);
    chk("check", 16'(pchk), 16'h0001);
    chk("exec", 16'(ex), 16'h0000);
    reg_acc(1'b0, rsc_pkg::REG_IRQ, 16'h0000);
    chk("status", rrd, 16'h000F);
    reg_acc(1'b0, rsc_pkg::REG_STATE, 16'h0000);
    chk("state", rrd, 16'h008D);
    // Mid-run reset clears the latch; then strap present and level 1 active
    @(posedge clk_i);
    nrst_i <= 1'b0;
    pn <= '{1'b1, 1'b0, 1'b1, rsc_pkg::SEL_ALL, 1'b1};
    lvl <= 2'h1;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    cyc(5);
    chk("check", 16'(pchk), 16'h0000);
    chk("exec", 16'(ex), 16'h0001);
    dn(1'b0, 1'b0, 16'h0000);
    st_acc(1'b0, 16'h0020, 16'h0000);
    chk("r0", srd, 16'h0002);
    st_acc(1'b0, 16'h0060, 16'h0000);
    chk("r0", srd, 16'h0000);
    err(1'b0);
    chk("check", 16'(pchk), 16'h0001);
    chk("exec", 16'(ex), 16'h0000);
    end_of_test();
  end
endmodule
